// File: logic/gbf_regs.svh
// Register offsets, flag bit positions, reset values and timing counts of the gauge flags
`ifndef GBF_REGS_SVH
`define GBF_REGS_SVH

// Register offsets (byte addresses on the plain port)
`define GBF_ADDR_FLAG1    8'h00
`define GBF_ADDR_FLAG2    8'h01
`define GBF_ADDR_NAC      8'h02
`define GBF_ADDR_LMD      8'h03
`define GBF_ADDR_INT_STAT 8'h04
`define GBF_ADDR_INT_MASK 8'h05
`define GBF_ADDR_STRAP    8'h06

// First flag register bit positions
`define GBF_F1_FINAL_END_VOLTAGE_FLAG 0
`define GBF_F1_FIRST_END_VOLTAGE_FLAG 1
`define GBF_F1_VDQ  3
`define GBF_F1_CI   4
`define GBF_F1_BRM  5
`define GBF_F1_BRP  6
`define GBF_F1_CHG  7

// Second flag register bit positions
`define GBF_F2_OVLD 0
`define GBF_F2_CR   7

// Interrupt status bit positions
`define GBF_IRQ_FIRST_END_VOLTAGE_FLAG 0
`define GBF_IRQ_FINAL_END_VOLTAGE_FLAG 1
`define GBF_IRQ_BRM  2
`define GBF_IRQ_BRP  3
`define GBF_IRQ_CI   4
`define GBF_IRQ_W    5

// Widths and reset values
`define GBF_DW        8
`define GBF_CNT_W     7
`define GBF_CI_LIMIT  7'h40
`define GBF_CNT_MAX   7'h7F
`define GBF_LMD_RST   8'hC0
`define GBF_ZERO8     8'h00
`define GBF_ONE8      8'h01
`define GBF_MASK_RST  5'h00

// Strap settle time per pull phase, in clock cycles
`define GBF_SETTLE_CNT 4'hF

// Self-discharge tick periods in clock cycles (two selectable rates)
`define GBF_SD_SLOW_CNT 12'hFA0
`define GBF_SD_FAST_CNT 12'h7D0

`endif

// File: logic/gbf_pkg.sv
// Types shared by the gauge flag logic
package gbf_pkg;

   // Decoded level of a three-state strap pin
   typedef enum logic [1:0] {
      TRI_LOW   = 2'b00,
      TRI_FLOAT = 2'b01,
      TRI_HIGH  = 2'b10
   } gbf_tri_type;

   // Strap sampling sequence
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_PULLU = 2'b01,
      ST_PULLD = 2'b10,
      ST_DONE  = 2'b11
   } gbf_strap_st_type;

   // Strap decoder state
   typedef struct packed {
      gbf_strap_st_type st;
      logic [3:0]       settle;
      logic [1:0]       up_seen;
      gbf_tri_type      rate_pin;
      gbf_tri_type      disp_pin;
      logic             pull_up;
      logic             done;
   } gbf_strap_state_type;

   // Self-discharge divider state
   typedef struct packed {
      logic [11:0] cnt;
      logic        tick;
   } gbf_div_state_type;

   // Battery sense inputs travelling together
   typedef struct packed {
      logic below_first;
      logic below_final;
      logic pack_absent;
      logic charging;
      logic chg_unit;
      logic dsg_unit;
      logic charge_cycle;
      logic fast_charge;
      logic overload;
   } gbf_sense_type;

   // Core state of the flag block
   typedef struct packed {
      logic       first_end;
      logic       final_end;
      logic       removed;
      logic       replaced;
      logic       valid_discharge_flag;
      logic       stale;
      logic       lmd_updated;
      logic [6:0] cyc_cnt;
      logic [7:0] available_charge;
      logic [7:0] last_measured_discharge;
      logic [4:0] int_stat;
      logic [4:0] int_mask;
      logic [7:0] rdata;
      logic       irq;
   } gbf_core_state_type;

endpackage : gbf_pkg

// File: logic/gbf_strap.sv
// Three-state strap pin sampler, run once after reset
`timescale 1ns/1ns
`default_nettype none
`include "gbf_regs.svh"

module gbf_strap (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Strap pads: bit 0 rate pin, bit 1 display pin
   input  wire logic [1:0]          prog_in,
   output logic                     prog_pull_up,
   // Decoded configuration
   output gbf_pkg::gbf_tri_type     rate_pin,
   output gbf_pkg::gbf_tri_type     disp_pin,
   output logic                     done
);

   gbf_pkg::gbf_strap_state_type st_ff;
   gbf_pkg::gbf_strap_state_type nxt_st;

   // High under both pulls, low under both, otherwise left open
   function automatic gbf_pkg::gbf_tri_type tri_decode(input logic up, input logic dn);
      if (up && dn) begin
         tri_decode = gbf_pkg::TRI_HIGH;
      end else if (!up && !dn) begin
         tri_decode = gbf_pkg::TRI_LOW;
      end else begin
         tri_decode = gbf_pkg::TRI_FLOAT;
      end
   endfunction : tri_decode

   // Sequence: pull up, sample, pull down, sample, then hold forever
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.st)
         gbf_pkg::ST_RESET: begin
            nxt_st.st      = gbf_pkg::ST_PULLU;
            nxt_st.pull_up = 1'b1;
            nxt_st.settle  = `GBF_SETTLE_CNT;
         end
         gbf_pkg::ST_PULLU: begin
            nxt_st.settle = st_ff.settle - 4'h1;
            if (st_ff.settle == 4'h0) begin
               nxt_st.up_seen = prog_in;
               nxt_st.pull_up = 1'b0;
               nxt_st.settle  = `GBF_SETTLE_CNT;
               nxt_st.st      = gbf_pkg::ST_PULLD;
            end
         end
         gbf_pkg::ST_PULLD: begin
            nxt_st.settle = st_ff.settle - 4'h1;
            if (st_ff.settle == 4'h0) begin
               // Pins are decoded only here; later changes wait for reset
               nxt_st.rate_pin = tri_decode(st_ff.up_seen[0], prog_in[0]);
               nxt_st.disp_pin = tri_decode(st_ff.up_seen[1], prog_in[1]);
               nxt_st.done     = 1'b1;
               nxt_st.st       = gbf_pkg::ST_DONE;
            end
         end
         gbf_pkg::ST_DONE: begin
            nxt_st.st = gbf_pkg::ST_DONE;
         end
         default: begin
            nxt_st.st = gbf_pkg::ST_RESET;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '{st: gbf_pkg::ST_RESET, settle: 4'h0, up_seen: 2'h0,
                    rate_pin: gbf_pkg::TRI_LOW, disp_pin: gbf_pkg::TRI_LOW,
                    pull_up: 1'b0, done: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prog_pull_up = st_ff.pull_up;
   assign rate_pin     = st_ff.rate_pin;
   assign disp_pin     = st_ff.disp_pin;
   assign done         = st_ff.done;

endmodule : gbf_strap
`default_nettype wire

// File: logic/gbf_sd_div.sv
// Self-discharge tick divider with two selectable periods
`timescale 1ns/1ns
`default_nettype none
`include "gbf_regs.svh"

module gbf_sd_div (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Control
   input  wire logic enable,
   input  wire logic rate_fast,
   // One-cycle tick
   output logic      tick
);

   gbf_pkg::gbf_div_state_type st_ff;
   gbf_pkg::gbf_div_state_type nxt_st;

   // Count down to zero, reload with the period of the strapped rate
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.tick = 1'b0;
      if (!enable) begin
         nxt_st.cnt = `GBF_SD_SLOW_CNT;
      end else if (st_ff.cnt == 12'h000) begin
         nxt_st.tick = 1'b1;
         nxt_st.cnt  = rate_fast ? `GBF_SD_FAST_CNT : `GBF_SD_SLOW_CNT;
      end else begin
         nxt_st.cnt = st_ff.cnt - 12'h001;
      end
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '{cnt: `GBF_SD_SLOW_CNT, tick: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;

endmodule : gbf_sd_div
`default_nettype wire

// File: logic/gbf_flags.sv
// Battery gauge status flags, capacity qualification and host registers
// -----------------------------------------------------------------------
// Overview of operation
// - First end flag sets below first threshold, clears when charging seen.
// - Final end flag sets below final threshold, clears when charging seen.
// - Pack removed flag sets on any removal condition, resets on return.
// - Pack replaced flag sets when pack returns after removal flag.
// - Replaced flag clears at first end level or charge to full.
// - Replaced flag is set by initialization.
// - Valid discharge sets when charged to full; clear blocks capacity update.
// - Capacity stale flag sets after 64 charge cycles without update.
// - Charge cycles are counted; counter zeroes at full after valid update.
// - Host write of available charge disqualifies the next discharge.
// - Strap pins sampled only after reset; changes need another reset.
// - Each strap pin decodes as high, floating or low.
// - One of two self-discharge rates chosen by a strap pin.
// - A strap pin selects relative or absolute full reference for display.
// - Charge rate bit in second flag register reports trickle or fast.
// -----------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "gbf_regs.svh"

module gbf_flags (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Battery sense inputs
   input  wire gbf_pkg::gbf_sense_type sense,
   // Strap pads
   input  wire logic [1:0]           prog_in,
   output logic                      prog_pull_up,
   // Register port
   input  wire logic [7:0]           addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic [7:0]                rdata,
   // Interrupt and display configuration
   output logic                      irq,
   output logic                      disp_absolute
);

   // --------------------------------------------------------------------
   // Strap sampling and self-discharge divider
   // --------------------------------------------------------------------
   gbf_pkg::gbf_tri_type rate_pin;
   gbf_pkg::gbf_tri_type disp_pin;
   logic                 strap_done;
   logic                 sd_tick;
   logic                 disp_abs_ff;

   gbf_strap u_strap (
      .clk          (clk),
      .resetn       (resetn),
      .prog_in      (prog_in),
      .prog_pull_up (prog_pull_up),
      .rate_pin     (rate_pin),
      .disp_pin     (disp_pin),
      .done         (strap_done)
   );

   // Only a strongly driven high picks the second rate; two rates exist
   gbf_sd_div u_sd_div (
      .clk       (clk),
      .resetn    (resetn),
      .enable    (strap_done),
      .rate_fast (rate_pin == gbf_pkg::TRI_HIGH),
      .tick      (sd_tick)
   );

   // Display reference follows the strap once it is decoded
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         disp_abs_ff <= 1'b0;
      end else begin
         disp_abs_ff <= strap_done && (disp_pin == gbf_pkg::TRI_HIGH);
      end
   end

   assign disp_absolute = disp_abs_ff;

   // --------------------------------------------------------------------
   // Core state
   // --------------------------------------------------------------------
   gbf_pkg::gbf_core_state_type st_ff;
   gbf_pkg::gbf_core_state_type nxt_st;

   logic [4:0] events;
   logic       at_full;
   logic       wr_nac;
   logic       wr_lmd;

   // Register select, used by the write decodes; reads decode addr in a case statement
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction : hit

   // Saturating step of an 8-bit count
   function automatic logic [7:0] sat_step(input logic [7:0] v, input logic up,
                                           input logic [7:0] lim);
      if (up) begin
         sat_step = (v < lim) ? v + `GBF_ONE8 : v;
      end else begin
         sat_step = (v != `GBF_ZERO8) ? v - `GBF_ONE8 : v;
      end
   endfunction : sat_step

   // First flag register image
   function automatic logic [7:0] flag1(input gbf_pkg::gbf_core_state_type s,
                                        input logic chg);
      flag1              = `GBF_ZERO8;
      flag1[`GBF_F1_FINAL_END_VOLTAGE_FLAG] = s.final_end;
      flag1[`GBF_F1_FIRST_END_VOLTAGE_FLAG] = s.first_end;
      flag1[`GBF_F1_VDQ]  = s.valid_discharge_flag;
      flag1[`GBF_F1_CI]   = s.stale;
      flag1[`GBF_F1_BRM]  = s.removed;
      flag1[`GBF_F1_BRP]  = s.replaced;
      flag1[`GBF_F1_CHG]  = chg;
   endfunction : flag1

   assign at_full = (st_ff.available_charge == st_ff.last_measured_discharge);
   assign wr_nac  = wr && hit(addr, `GBF_ADDR_NAC);
   assign wr_lmd  = wr && hit(addr, `GBF_ADDR_LMD);

   // Rising edges of flags raise interrupt events
   always_comb begin
      events                = `GBF_MASK_RST;
      events[`GBF_IRQ_FIRST_END_VOLTAGE_FLAG] = sense.below_first && !st_ff.first_end;
      events[`GBF_IRQ_FINAL_END_VOLTAGE_FLAG] = sense.below_final && !st_ff.final_end;
      events[`GBF_IRQ_BRM]  = sense.pack_absent && !st_ff.removed;
      events[`GBF_IRQ_BRP]  = st_ff.removed && !sense.pack_absent && !st_ff.replaced;
      // Stale rise is folded in by the next-state process, which avoids a combinational loop
   end

   // Next state: flags, counters, charge registers, host port
   always_comb begin
      nxt_st = st_ff;

      // End-of-discharge latches; a set in the charging cycle still wins
      if (sense.charging) begin
         nxt_st.first_end = 1'b0;
         nxt_st.final_end = 1'b0;
      end
      if (sense.below_first) begin
         nxt_st.first_end = 1'b1;
      end
      if (sense.below_final) begin
         nxt_st.final_end = 1'b1;
      end

      // Removal follows the removal condition as a one-cycle registered copy, without latching
      if (sense.pack_absent) begin
         nxt_st.removed = 1'b1;
      end else begin
         nxt_st.removed = 1'b0;
      end

      // Replacement: cleared at first end level or when charged to full
      if (events[`GBF_IRQ_FIRST_END_VOLTAGE_FLAG] || (sense.charging && at_full)) begin
         nxt_st.replaced = 1'b0;
      end
      if (st_ff.removed && !sense.pack_absent) begin
         nxt_st.replaced = 1'b1;
      end

      // A host write of available charge spoils the next discharge
      if (wr_nac) begin
         nxt_st.valid_discharge_flag = 1'b0;
      end

      // Qualified discharge ending at first end level updates capacity
      if (events[`GBF_IRQ_FIRST_END_VOLTAGE_FLAG] && st_ff.valid_discharge_flag) begin
         nxt_st.last_measured_discharge         = (st_ff.last_measured_discharge > st_ff.available_charge) ? st_ff.last_measured_discharge - st_ff.available_charge : `GBF_ONE8;
         nxt_st.lmd_updated = 1'b1;
         nxt_st.valid_discharge_flag         = 1'b0;
      end
      if (sense.charging && at_full) begin
         nxt_st.valid_discharge_flag = 1'b1;
      end

      // Charge cycles since the last capacity update
      if (sense.charge_cycle && st_ff.cyc_cnt != `GBF_CNT_MAX) begin
         nxt_st.cyc_cnt = st_ff.cyc_cnt + 7'h01;
      end
      if (at_full && st_ff.lmd_updated) begin
         nxt_st.cyc_cnt     = 7'h00;
         nxt_st.lmd_updated = 1'b0;
      end
      nxt_st.stale = (nxt_st.cyc_cnt >= `GBF_CI_LIMIT);

      // Available charge: host load, else counting and self-discharge
      if (wr_nac) begin
         nxt_st.available_charge = wdata;
      end else if (sense.chg_unit) begin
         nxt_st.available_charge = sat_step(st_ff.available_charge, 1'b1, st_ff.last_measured_discharge);
      end else if (sense.dsg_unit || sd_tick) begin
         nxt_st.available_charge = sat_step(st_ff.available_charge, 1'b0, st_ff.last_measured_discharge);
      end
      if (wr_lmd) begin
         nxt_st.last_measured_discharge = wdata;
      end

      // Interrupts: write one to clear, a new event wins over the clear
      nxt_st.int_stat = st_ff.int_stat & ~((wr && hit(addr, `GBF_ADDR_INT_STAT)) ?
                                           wdata[4:0] : `GBF_MASK_RST);
      nxt_st.int_stat = nxt_st.int_stat | events;
      // Stale rise comes from the freshly computed flag, so it needs no extra cycle
      nxt_st.int_stat[`GBF_IRQ_CI] = nxt_st.int_stat[`GBF_IRQ_CI] | (nxt_st.stale && !st_ff.stale);
      if (wr && hit(addr, `GBF_ADDR_INT_MASK)) begin
         nxt_st.int_mask = wdata[4:0];
      end
      nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);

      // Read data stand only in the cycle after the strobe
      nxt_st.rdata = `GBF_ZERO8;
      if (rd) begin
         case (addr)
            `GBF_ADDR_FLAG1: begin
               nxt_st.rdata = flag1(st_ff, sense.charging);
            end
            `GBF_ADDR_FLAG2: begin
               nxt_st.rdata[`GBF_F2_OVLD] = sense.overload;
               nxt_st.rdata[`GBF_F2_CR]   = sense.fast_charge;
            end
            `GBF_ADDR_NAC: begin
               nxt_st.rdata = st_ff.available_charge;
            end
            `GBF_ADDR_LMD: begin
               nxt_st.rdata = st_ff.last_measured_discharge;
            end
            `GBF_ADDR_INT_STAT: begin
               nxt_st.rdata = {3'h0, st_ff.int_stat};
            end
            `GBF_ADDR_INT_MASK: begin
               nxt_st.rdata = {3'h0, st_ff.int_mask};
            end
            `GBF_ADDR_STRAP: begin
               nxt_st.rdata = {3'h0, strap_done, disp_pin, rate_pin};
            end
            default: begin
               nxt_st.rdata = `GBF_ZERO8;
            end
         endcase
      end
   end

   // State register; the replaced flag comes out of reset set
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '{first_end: 1'b0, final_end: 1'b0, removed: 1'b0,
                    replaced: 1'b1,
                    valid_discharge_flag: 1'b0, stale: 1'b0, lmd_updated: 1'b0,
                    cyc_cnt: 7'h00, available_charge: `GBF_ZERO8, last_measured_discharge: `GBF_LMD_RST,
                    int_stat: `GBF_MASK_RST, int_mask: `GBF_MASK_RST,
                    rdata: `GBF_ZERO8, irq: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata = st_ff.rdata;
   assign irq   = st_ff.irq;

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking ast_clk @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence seq_pack_out;
      sense.pack_absent ##1 st_ff.removed;
   endsequence

   sequence seq_pack_back;
      !sense.pack_absent;
   endsequence

   sequence seq_charge_full;
      sense.charging && at_full;
   endsequence

   AST_FIRST_END_VOLTAGE_FLAG_SET: assert property (sense.below_first |=> st_ff.first_end)
      else $error("first end flag not set below threshold");

   AST_FIRST_END_VOLTAGE_FLAG_CLR: assert property ((sense.charging && !sense.below_first)
                                  |=> !st_ff.first_end)
      else $error("first end flag not cleared by charging");

   AST_FINAL_END_VOLTAGE_FLAG_HOLD: assert property ((st_ff.final_end && !sense.charging)
                                   |=> st_ff.final_end)
      else $error("final end flag dropped without charging");

   AST_BRM_SET: assert property (sense.pack_absent |=> st_ff.removed)
      else $error("removed flag not set");

   AST_BRP_SET: assert property (seq_pack_out ##0 seq_pack_back
                                 |=> st_ff.replaced && !st_ff.removed)
      else $error("replaced flag not set on pack return");

   AST_BRP_CLR: assert property ((events[`GBF_IRQ_FIRST_END_VOLTAGE_FLAG] && !st_ff.removed)
                                 |=> !st_ff.replaced)
      else $error("replaced flag not cleared at first end");

   AST_VDQ_SET: assert property (seq_charge_full |=> st_ff.valid_discharge_flag)
      else $error("valid discharge not set at full");

   AST_NAC_WR: assert property ((wr_nac && !(sense.charging && at_full))
                                |=> !st_ff.valid_discharge_flag && st_ff.available_charge == $past(wdata))
      else $error("host charge write did not disqualify");

   AST_CI_CNT: assert property ((st_ff.cyc_cnt == (`GBF_CI_LIMIT - 7'h01) && sense.charge_cycle
                                 && !(at_full && st_ff.lmd_updated))
                                |=> st_ff.stale)
      else $error("stale flag not set at 64 cycles");

   AST_CNT_RST: assert property ((at_full && st_ff.lmd_updated)
                                 |=> st_ff.cyc_cnt == 7'h00 && !st_ff.stale)
      else $error("cycle counter not cleared");

   AST_CR_READ: assert property ((rd && addr == `GBF_ADDR_FLAG2)
                                 |=> rdata[`GBF_F2_CR] == $past(sense.fast_charge))
      else $error("charge rate bit misreported");

   AST_STRAP_HOLD: assert property ((strap_done && $past(strap_done))
                                    |-> $stable(rate_pin) && $stable(disp_pin))
      else $error("strap changed after sampling");

   AST_FINAL_END_VOLTAGE_FLAG_SET: assert property (sense.below_final |=> st_ff.final_end)
      else $error("final end flag not set below threshold");

   AST_BRM_CLR: assert property (!sense.pack_absent |=> !st_ff.removed)
      else $error("removed flag not reset on pack return");

   // Read data must fall back to zero, so a stale word never looks like a fresh read
   AST_RD_IDLE: assert property (!rd |=> rdata == `GBF_ZERO8)
      else $error("read data present without a read strobe");

   AST_CI_IRQ: assert property ($rose(st_ff.stale) |-> st_ff.int_stat[`GBF_IRQ_CI])
      else $error("stale rise did not raise its status bit");

endmodule : gbf_flags
`default_nettype wire

// File: sim/gbf_pad_model.sv
// Strap pad model: each pad driven low, left floating or driven high
`timescale 1ns/1ns
`default_nettype none

module gbf_pad_model (
   // Pad setup, two bits a pad: 0 low, 1 floating, 2 high
   input  wire logic [3:0] mode,
   // Device pull direction and sensed pad levels
   input  wire logic       pull_up,
   output logic [1:0]      pad
);
   // A floating pad has no driver, so it follows whichever pull the device applies
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pad[i] = (mode[2*i +: 2] == 2'h1) ? pull_up : mode[2*i+1];
      end
   end
endmodule : gbf_pad_model

`default_nettype wire

// File: sim/tb_gbf_flags.sv
// Self-checking bench for the gauge flag block
`timescale 1ns/1ns
`default_nettype none
`include "gbf_regs.svh"

module tb_gbf_flags;
   // Sense patterns: first, final, absent, charging, cycle, fast, overload
   localparam logic [8:0] S_FIRST = 9'h100;
   localparam logic [8:0] S_FINAL = 9'h080;
   localparam logic [8:0] S_ABS   = 9'h040;
   localparam logic [8:0] S_CHG   = 9'h020;
   localparam logic [8:0] S_CYC   = 9'h004;
   localparam logic [8:0] S_FAST  = 9'h002;
   localparam logic [8:0] S_OVL   = 9'h001;
   logic                   clk    = 1'b0;
   logic                   resetn = 1'b0;
   gbf_pkg::gbf_sense_type sense  = '0;
   logic [7:0]             addr   = 8'h00;
   logic [7:0]             wdata  = 8'h00;
   logic                   wr     = 1'b0;
   logic                   rd     = 1'b0;
   logic [3:0]             mode   = 4'h6;
   logic [1:0]             prog_in;
   logic                   prog_pull_up;
   logic [7:0]             rdata;
   logic                   irq;
   logic                   disp_absolute;
   int                     num_errors = 0;
   int                     n_tests = 0;

   // Clock, 10 ns period
   always #5 clk = ~clk;

   gbf_flags u_gbf_flags (.clk(clk), .resetn(resetn), .sense(sense), .prog_in(prog_in),
      .prog_pull_up(prog_pull_up), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq), .disp_absolute(disp_absolute));
   gbf_pad_model u_gbf_pad_model (.mode(mode), .pull_up(prog_pull_up), .pad(prog_in));

   // -------------------------------
   // Access and compare tasks
   // -------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic put(input logic [8:0] v);
      @(posedge clk);
      sense <= v;
   endtask : put

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic fail(input string m);
      num_errors++;
      $display("ERROR at %0t: %s", $time, m);
   endtask : fail

   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd_reg(a, v);
      n_tests++;
      if (v !== e) fail($sformatf("reg %h read %h expected %h", a, v, e));
   endtask : chk_reg

   task automatic chk1(input logic g, input logic e);
      n_tests++;
      if (g !== e) fail($sformatf("bit read %b expected %b", g, e));
   endtask : chk1

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // Reset, then poll strap completion under a bound
   task automatic do_reset;
      logic [7:0] v;
      int         i;
      @(posedge clk);
      resetn <= 1'b0;
      cyc(16);
      resetn <= 1'b1;
      cyc(2);
      #1 chk1(prog_pull_up, 1'b1);
      for (i = 0; i < 40; i++) begin
         rd_reg(`GBF_ADDR_STRAP, v);
         if (v[4] === 1'b1) break;
      end
      if (i == 40) begin
         fail("strap never done");
         wrap_up();
      end
   endtask : do_reset

   // -------------------------------
   // Test sequence
   // -------------------------------
   initial begin
      do_reset();
      chk_reg(`GBF_ADDR_FLAG1, 8'h40);
      chk_reg(`GBF_ADDR_LMD, 8'hC0);
      chk_reg(`GBF_ADDR_STRAP, 8'h16);
      chk1(disp_absolute, 1'b0);
      chk_reg(8'h07, 8'h00);
      mode <= 4'h8;
      cyc(40);
      chk_reg(`GBF_ADDR_STRAP, 8'h16);
      $display("test reset_strap done");
      // End flags latch; the first end rise also drops the replaced flag
      wr_reg(`GBF_ADDR_INT_MASK, 8'h1F);
      put(S_FIRST | S_FINAL);
      put(9'h000);
      #1 chk1(irq, 1'b1);
      chk_reg(`GBF_ADDR_FLAG1, 8'h03);
      chk_reg(`GBF_ADDR_INT_STAT, 8'h03);
      wr_reg(`GBF_ADDR_INT_STAT, 8'h1F);
      #1 chk1(irq, 1'b0);
      put(S_CHG);
      chk_reg(`GBF_ADDR_FLAG1, 8'h80);
      put(9'h000);
      $display("test end_flags done");
      // Removal with events masked
      wr_reg(`GBF_ADDR_INT_MASK, 8'h00);
      put(S_ABS);
      cyc(2);
      chk_reg(`GBF_ADDR_FLAG1, 8'h20);
      put(9'h000);
      cyc(2);
      chk_reg(`GBF_ADDR_FLAG1, 8'h40);
      chk_reg(`GBF_ADDR_INT_STAT, 8'h0C);
      chk1(irq, 1'b0);
      $display("test removal done");
      // Qualification, host write, cycle count and capacity update
      wr_reg(`GBF_ADDR_LMD, 8'h05);
      wr_reg(`GBF_ADDR_NAC, 8'h05);
      put(S_CHG);
      put(9'h000);
      chk_reg(`GBF_ADDR_FLAG1, 8'h08);
      wr_reg(`GBF_ADDR_NAC, 8'h05);
      chk_reg(`GBF_ADDR_FLAG1, 8'h00);
      put(S_CHG);
      put(9'h000);
      for (int i = 0; i < 63; i++) begin
         put(S_CYC);
         put(9'h000);
      end
      chk_reg(`GBF_ADDR_FLAG1, 8'h08);
      put(S_CYC);
      put(9'h000);
      chk_reg(`GBF_ADDR_FLAG1, 8'h18);
      put(S_FIRST);
      put(9'h000);
      chk_reg(`GBF_ADDR_LMD, 8'h01);
      chk_reg(`GBF_ADDR_FLAG1, 8'h12);
      wr_reg(`GBF_ADDR_NAC, 8'h01);
      chk_reg(`GBF_ADDR_FLAG1, 8'h02);
      $display("test capacity done");
      // Charge rate and overload bits
      put(S_FAST | S_OVL);
      chk_reg(`GBF_ADDR_FLAG2, 8'h81);
      put(S_OVL);
      chk_reg(`GBF_ADDR_FLAG2, 8'h01);
      put(9'h000);
      $display("test flag2 done");
      // Fast strap: first period is slow, then fast ones, so two ticks fit in 7000 cycles
      wr_reg(`GBF_ADDR_NAC, 8'h10);
      cyc(7000);
      chk_reg(`GBF_ADDR_NAC, 8'h0E);
      $display("test fast self-discharge done");
      // New strapping is taken only by a fresh reset
      do_reset();
      chk_reg(`GBF_ADDR_STRAP, 8'h18);
      chk1(disp_absolute, 1'b1);
      // Slow strap: only one tick fits in the same 7000 cycles
      wr_reg(`GBF_ADDR_NAC, 8'h10);
      cyc(7000);
      chk_reg(`GBF_ADDR_NAC, 8'h0F);
      $display("test restrap done");
      wrap_up();
   end
endmodule : tb_gbf_flags

`default_nettype wire
